// >>> design/imsp_device.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Host sends 16 clocks per word, 17 in the realign frame
// - Clock counts off a multiple of 16 break word alignment
// - Seventeen-edge frame realigns after overrun
// - Host attempts recovery at most 15 times
// - Short frame locks port until hard reset
// - Host reads at most 12 per ready at decimation setting 0
// - Too many reads set overrun flag
// - Host gap stays near minimum gap
// - Read budget scales with decimation factor
// - Decimation sums setting plus one samples
// - Smoothing stages sum two-power-setting samples
// - One extra bit per summation doubling
// - Default gyro fills upper word exactly
// - Lower word holds growth bits
// - Default accel: 20 bits, four below
// - Burst returns upper words of all six outputs only
module imsp_device #(
  parameter logic [15:0] PRODUCT_ID = imsp_pkg::PROD_NUM_DEF,
  parameter int DEC_W = imsp_pkg::DEC_W,
  parameter int FILT_W = imsp_pkg::FILT_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Link
  imsp_link_if.dev lnk,
  // Raw sensor samples
  input wire logic raw_valid_in,
  input wire logic [2:0][imsp_pkg::GYRO_W-1:0] raw_gyro_in,
  input wire logic [2:0][imsp_pkg::ACCEL_W-1:0] raw_accel_in,
  // Status
  output logic port_locked_out
);
  localparam int AW = imsp_pkg::ACC_W;

  typedef struct packed {
    logic [3:0] pos;
    logic [4:0] edges;
    logic locked;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] cmd;
    logic cmd_tgl;
  } imsp_dev_lk_t;

  typedef struct packed {
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic lk_s1;
    logic lk_s2;
    logic [DEC_W-1:0] dec;
    logic [DEC_W-1:0] c0;
    logic [FILT_W-1:0] filt;
    logic [7:0] c1;
    logic [7:0] c2;
    logic ovr;
    logic [7:0] rd_cnt;
    logic [2:0] burst;
    logic [15:0] resp;
    logic rdy;
    logic [5:0][AW-1:0] a0;
    logic [5:0][AW-1:0] a1;
    logic [5:0][AW-1:0] a2;
    logic [5:0][31:0] out;
  } imsp_dev_sys_t;

  imsp_dev_lk_t lk_q, lk_d;
  imsp_dev_sys_t sy_q, sy_d;
  logic rst;
  logic in_frame_q;

  // Bits of growth over the raw width
  function automatic logic [4:0] growth(input logic [DEC_W-1:0] d, input logic [FILT_W-1:0] f);
    logic [4:0] g;
    g = 5'({f, 1'b0});
    for (int k = 0; k < DEC_W; k++)
    begin
      if ((32'(d) + 32'd1) > (32'd1 << k))
        g = g + 5'd1;
    end
    return g;
  endfunction

  // Places a result MSB-aligned across upper and lower words
  function automatic logic [31:0] place(input logic [AW-1:0] a, input logic [4:0] sh);
    logic [AW-1:0] s;
    s = a << sh;
    return s[31:0];
  endfunction

  // Hard reset pin or system reset clears both domains
  assign rst = reset_in | lnk.hard_rst;

  // Frame presence, cleared while chip select is high
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n or posedge rst)
  begin
    if (rst)
      in_frame_q <= 1'b0;
    else if (lnk.cs_n)
      in_frame_q <= 1'b0;
    else
      in_frame_q <= 1'b1;
  end

  // Link side: word alignment, shifting, lock
  always_comb
  begin
    lk_d = lk_q;
    if (!in_frame_q)
    begin
      // Judge the previous frame at the first edge of this one
      if (lk_q.pos != 4'h0 && lk_q.edges < 5'(imsp_pkg::WORD_W))
      begin
        lk_d.locked = 1'b1;
        lk_d.tx = '0;
      end
      if (lk_q.edges == 5'(imsp_pkg::RECOVER_EDGES))
        lk_d.pos = 4'h0;
      lk_d.edges = 5'd1;
    end
    else if (lk_q.edges != 5'h1f)
      lk_d.edges = lk_q.edges + 5'd1;
    if (!lk_d.locked)
    begin
      lk_d.rx = {lk_q.rx[14:0], lnk.mosi};
      // Answer is loaded at the first bit of each word
      lk_d.tx = (lk_d.pos == 4'h0) ? sy_q.resp : {lk_q.tx[14:0], 1'b0};
      if (lk_d.pos == 4'hf)
      begin
        // Word boundary follows the running bit count, not the frame
        lk_d.cmd = lk_d.rx;
        lk_d.cmd_tgl = !lk_q.cmd_tgl;
      end
      lk_d.pos = lk_d.pos + 4'h1;
    end
  end

  // Link side registers
  always_ff @(posedge lnk.sclk or posedge rst)
  begin
    if (rst)
      lk_q <= '0;
    else
      lk_q <= lk_d;
  end

  assign lnk.miso = lk_q.tx[15] & !lk_q.locked;

  // System side: filters, command decode, diagnostics
  always_comb
  begin
    logic ev;
    logic wr;
    logic rdy_now;
    logic ovr_set;
    logic [6:0] a;
    logic [6:0] idx;
    logic [7:0] limit;
    logic [7:0] nsum;
    logic [4:0] g;
    sy_d = sy_q;
    ev = 1'b0;
    wr = 1'b0;
    rdy_now = 1'b0;
    ovr_set = 1'b0;
    a = lk_q.cmd[imsp_pkg::CMD_ADDR_LSB +: 7];
    idx = a - imsp_pkg::ADDR_DATA_LO;
    limit = 8'(imsp_pkg::READS_PER_READY * (int'(sy_q.dec) + 1));
    nsum = 8'((32'd1 << sy_q.filt) - 32'd1);
    g = growth(sy_q.dec, sy_q.filt);
    sy_d.rdy = 1'b0;
    // Two-flop crossings from the link side
    sy_d.tg_s1 = lk_q.cmd_tgl;
    sy_d.tg_s2 = sy_q.tg_s1;
    sy_d.tg_s3 = sy_q.tg_s2;
    sy_d.lk_s1 = lk_q.locked;
    sy_d.lk_s2 = sy_q.lk_s1;
    ev = sy_q.tg_s2 != sy_q.tg_s3;
    // Decimation then two smoothing stages
    if (raw_valid_in)
    begin
      for (int i = 0; i < 3; i++)
      begin
        sy_d.a0[i] = sy_q.a0[i] + AW'({{(AW-16){raw_gyro_in[i][15]}}, raw_gyro_in[i]});
        sy_d.a0[i+3] = sy_q.a0[i+3] + AW'({{(AW-20){raw_accel_in[i][19]}}, raw_accel_in[i]});
      end
      if (sy_q.c0 >= sy_q.dec)
      begin
        sy_d.c0 = '0;
        for (int i = 0; i < 6; i++)
        begin
          sy_d.a1[i] = sy_q.a1[i] + sy_d.a0[i];
          sy_d.a0[i] = '0;
        end
        if (sy_q.c1 >= nsum)
        begin
          sy_d.c1 = '0;
          for (int i = 0; i < 6; i++)
          begin
            sy_d.a2[i] = sy_q.a2[i] + sy_d.a1[i];
            sy_d.a1[i] = '0;
          end
          if (sy_q.c2 >= nsum)
          begin
            sy_d.c2 = '0;
            for (int i = 0; i < 6; i++)
            begin
              // Gyro default fills the upper word; accel leaves four low bits
              sy_d.out[i] = place(sy_d.a2[i], (i < 3) ? 5'd16 - g : 5'd12 - g);
              sy_d.a2[i] = '0;
            end
            rdy_now = 1'b1;
          end
          else
            sy_d.c2 = sy_q.c2 + 8'd1;
        end
        else
          sy_d.c1 = sy_q.c1 + 8'd1;
      end
      else
        sy_d.c0 = sy_q.c0 + DEC_W'(1);
    end
    // Command execution; answer goes out in the next word
    if (ev)
    begin
      wr = lk_q.cmd[imsp_pkg::CMD_WR_BIT];
      if (wr)
      begin
        if (a == imsp_pkg::ADDR_DEC)
          sy_d.dec = lk_q.cmd[DEC_W-1:0];
        if (a == imsp_pkg::ADDR_FILT)
          sy_d.filt = lk_q.cmd[FILT_W-1:0];
        sy_d.resp = '0;
        sy_d.burst = '0;
      end
      else
      begin
        if (sy_q.rd_cnt >= limit)
          ovr_set = 1'b1;
        else
          sy_d.rd_cnt = sy_q.rd_cnt + 8'd1;
        if (sy_q.burst != 3'd0)
        begin
          // Burst words carry upper words only
          sy_d.resp = sy_q.out[sy_q.burst][31:16];
          sy_d.burst = (sy_q.burst == 3'(imsp_pkg::BURST_WORDS - 1)) ? 3'd0 : sy_q.burst + 3'd1;
        end
        else if (a == imsp_pkg::ADDR_BURST)
        begin
          sy_d.resp = sy_q.out[0][31:16];
          sy_d.burst = 3'd1;
        end
        else if (a >= imsp_pkg::ADDR_DATA_LO && a <= imsp_pkg::ADDR_DATA_HI)
          sy_d.resp = idx[1] ? sy_q.out[idx[4:2]][31:16] : sy_q.out[idx[4:2]][15:0];
        else
        begin
          unique case (a)
            imsp_pkg::ADDR_DIAG:
            begin
              sy_d.resp = 16'(sy_q.ovr) << imsp_pkg::DIAG_OVR_BIT;
              sy_d.ovr = 1'b0;
            end
            imsp_pkg::ADDR_FILT: sy_d.resp = 16'(sy_q.filt);
            imsp_pkg::ADDR_DEC: sy_d.resp = 16'(sy_q.dec);
            imsp_pkg::ADDR_PROD: sy_d.resp = PRODUCT_ID;
            default: sy_d.resp = '0;
          endcase
        end
      end
    end
    // New sample opens a new read budget; a set beats a clear
    if (rdy_now)
    begin
      sy_d.rdy = 1'b1;
      sy_d.rd_cnt = '0;
    end
    if (ovr_set)
      sy_d.ovr = 1'b1;
  end

  // System side registers
  always_ff @(posedge clk_sys_in or posedge rst)
  begin
    if (rst)
    begin
      sy_q <= '0;
      sy_q.dec <= imsp_pkg::DEC_RST;
      sy_q.filt <= imsp_pkg::FILT_RST;
    end
    else
      sy_q <= sy_d;
  end

  assign lnk.sample_ready_pulse = sy_q.rdy;
  assign port_locked_out = sy_q.lk_s2;
endmodule // imsp_device
`default_nettype wire

// >>> design/imsp_host.sv
`timescale 1ns/10ps
`default_nettype none
module imsp_host #(
  parameter logic [15:0] PRODUCT_ID = imsp_pkg::PROD_NUM_DEF,
  parameter int DEC_W = imsp_pkg::DEC_W,
  parameter int HALF = imsp_pkg::HALF_CYC,
  parameter int GAP = imsp_pkg::GAP_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Link
  imsp_link_if.host lnk,
  // Requests
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [6:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  output logic req_ready_out,
  // Answers
  output logic ans_valid_out,
  output logic [15:0] ans_data_out,
  // Recovery and hard reset
  input wire logic recover_in,
  input wire logic hard_reset_in,
  output logic rec_busy_out,
  output logic rec_ok_out,
  output logic rec_fail_out
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LEAD = 5'b00010,
    ST_SHIFT = 5'b00100,
    ST_TAIL = 5'b01000,
    ST_GAP = 5'b10000
  } imsp_host_st_t;

  typedef struct packed {
    imsp_host_st_t st;
    logic [7:0] div;
    logic [15:0] gap;
    logic [4:0] bits;
    logic [4:0] nbits;
    logic [15:0] tx;
    logic [15:0] rx;
    logic sclk;
    logic cs_n;
    logic ans_v;
    logic [15:0] ans;
    logic [1:0] rec;
    logic [3:0] tries;
    logic ok;
    logic fail;
    logic [DEC_W-1:0] dec;
    logic [7:0] rd_cnt;
    logic [7:0] hrst;
    logic mi_s1;
    logic mi_s2;
    logic dr_s1;
    logic dr_s2;
    logic dr_s3;
  } imsp_host_t;

  imsp_host_t q, d;
  logic ready;

  // Request acceptance, throttled by the read budget
  always_comb
  begin
    logic [7:0] limit;
    limit = 8'(imsp_pkg::READS_PER_READY * (int'(q.dec) + 1));
    ready = q.st == ST_IDLE && q.rec == 2'd0 && q.hrst == 8'd0 && !recover_in
      && (req_write_in || q.rd_cnt < limit);
  end

  // Frame sequencer and recovery loop
  always_comb
  begin
    d = q;
    d.ans_v = 1'b0;
    d.mi_s1 = lnk.miso;
    d.mi_s2 = q.mi_s1;
    d.dr_s1 = lnk.sample_ready_pulse;
    d.dr_s2 = q.dr_s1;
    d.dr_s3 = q.dr_s2;
    if (q.dr_s2 && !q.dr_s3)
      d.rd_cnt = '0;
    if (q.hrst != 8'd0)
      d.hrst = q.hrst - 8'd1;
    unique case (q.st)
      ST_IDLE:
      begin
        if (q.rec != 2'd0)
        begin
          // Seventeen clocks, then two reads of the product number
          d.tx = (q.rec == 2'd1) ? 16'h0000 : {1'b0, imsp_pkg::ADDR_PROD, 8'h00};
          d.nbits = (q.rec == 2'd1) ? 5'(imsp_pkg::RECOVER_EDGES) : 5'(imsp_pkg::WORD_W);
          d.st = ST_LEAD;
          d.cs_n = 1'b0;
          d.div = '0;
        end
        else if (req_valid_in && ready)
        begin
          d.tx = {req_write_in, req_addr_in, req_data_in};
          d.nbits = 5'(imsp_pkg::WORD_W);
          if (req_write_in && req_addr_in == imsp_pkg::ADDR_DEC)
            d.dec = req_data_in[DEC_W-1:0];
          if (!req_write_in)
            d.rd_cnt = q.rd_cnt + 8'd1;
          d.st = ST_LEAD;
          d.cs_n = 1'b0;
          d.div = '0;
        end
        else if (recover_in)
        begin
          d.rec = 2'd1;
          d.tries = '0;
          d.ok = 1'b0;
          d.fail = 1'b0;
        end
      end
      ST_LEAD:
      begin
        d.div = q.div + 8'd1;
        if (q.div == 8'(HALF - 1))
        begin
          d.st = ST_SHIFT;
          d.sclk = 1'b0;
          d.div = '0;
          d.bits = '0;
        end
      end
      ST_SHIFT:
      begin
        d.div = q.div + 8'd1;
        if (q.div == 8'(HALF - 1))
        begin
          d.div = '0;
          if (!q.sclk)
            d.sclk = 1'b1;
          else
          begin
            // Sample at the end of the high phase, then shift
            d.rx = {q.rx[14:0], q.mi_s2};
            d.bits = q.bits + 5'd1;
            if (d.bits == q.nbits)
              d.st = ST_TAIL;
            else
            begin
              // Data moves only with the falling clock, never while it is high
              d.tx = {q.tx[14:0], 1'b0};
              d.sclk = 1'b0;
            end
          end
        end
      end
      ST_TAIL:
      begin
        d.div = q.div + 8'd1;
        if (q.div == 8'(HALF - 1))
        begin
          d.cs_n = 1'b1;
          d.st = ST_GAP;
          d.gap = '0;
          d.ans_v = 1'b1;
          d.ans = q.rx;
          unique case (q.rec)
            2'd0: d.rec = 2'd0;
            2'd1: d.rec = 2'd2;
            2'd2: d.rec = 2'd3;
            2'd3:
            begin
              d.rec = 2'd0;
              if (q.rx == PRODUCT_ID)
                d.ok = 1'b1;
              else if (q.tries == 4'(imsp_pkg::RECOVER_TRIES - 1))
                d.fail = 1'b1;
              else
              begin
                d.tries = q.tries + 4'd1;
                d.rec = 2'd1;
              end
            end
          endcase
        end
      end
      ST_GAP:
      begin
        // Minimum gap plus one idle cycle, keeping within ten percent
        d.gap = q.gap + 16'd1;
        if (q.gap == 16'(GAP - 1))
          d.st = ST_IDLE;
      end
    endcase
    if (hard_reset_in)
    begin
      // Hard reset pulse restores a locked port
      d.hrst = 8'(imsp_pkg::HRST_CYC);
      d.st = ST_IDLE;
      d.cs_n = 1'b1;
      d.sclk = 1'b1;
      d.rec = 2'd0;
      d.rd_cnt = '0;
      d.dec = imsp_pkg::DEC_RST;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.sclk <= 1'b1;
      q.cs_n <= 1'b1;
      q.dec <= imsp_pkg::DEC_RST;
    end
    else
      q <= d;
  end

  assign lnk.sclk = q.sclk;
  assign lnk.cs_n = q.cs_n;
  assign lnk.mosi = q.tx[15];
  assign lnk.hard_rst = q.hrst != 8'd0;
  assign req_ready_out = ready;
  assign ans_valid_out = q.ans_v;
  assign ans_data_out = q.ans;
  assign rec_busy_out = q.rec != 2'd0;
  assign rec_ok_out = q.ok;
  assign rec_fail_out = q.fail;
endmodule // imsp_host
`default_nettype wire

// >>> shared/imsp_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface imsp_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic sample_ready_pulse;
  logic hard_rst;
  modport dev (input sclk, cs_n, mosi, hard_rst, output miso, sample_ready_pulse);
  modport host (output sclk, cs_n, mosi, hard_rst, input miso, sample_ready_pulse);
endinterface
`default_nettype wire

// >>> shared/imsp_pkg.sv
package imsp_pkg;
  // Link framing
  localparam int WORD_W = 16;
  localparam int RECOVER_EDGES = 17;
  localparam int RECOVER_TRIES = 15;
  localparam int READS_PER_READY = 12;
  // Timing, in ns and in system clock cycles
  localparam int CLK_NS = 40;
  localparam int GAP_NS = 16000;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC = 4;
  localparam int HRST_CYC = 8;
  // Data widths
  localparam int GYRO_W = 16;
  localparam int ACCEL_W = 20;
  localparam int DEC_W = 4;
  localparam int FILT_W = 2;
  localparam int ACC_W = 40;
  localparam int BURST_WORDS = 6;
  // Arbitrary product number value
  localparam logic [15:0] PROD_NUM_DEF = 16'h2b71;
  // Command word layout
  localparam int CMD_WR_BIT = 15;
  localparam int CMD_ADDR_LSB = 8;
  // Register addresses
  localparam logic [6:0] ADDR_DIAG = 7'h02;
  localparam logic [6:0] ADDR_DATA_LO = 7'h04;
  localparam logic [6:0] ADDR_DATA_HI = 7'h1a;
  localparam logic [6:0] ADDR_FILT = 7'h20;
  localparam logic [6:0] ADDR_DEC = 7'h22;
  localparam logic [6:0] ADDR_PROD = 7'h24;
  localparam logic [6:0] ADDR_BURST = 7'h3e;
  // Diagnostic flag position and reset values
  localparam int DIAG_OVR_BIT = 1;
  localparam logic [DEC_W-1:0] DEC_RST = 4'h0;
  localparam logic [FILT_W-1:0] FILT_RST = 2'h0;
endpackage

// >>> verification/imsp_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module imsp_link_assertions (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sample_ready_pulse,
  input wire logic hard_rst
);
  typedef struct packed {
    logic [5:0] edges;
    logic sclk_prev;
  } imsp_chk_t;
  imsp_chk_t chk_q;
  imsp_chk_t chk_d;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in || hard_rst);
  // Count link clock rises inside a frame
  always_comb
  begin
    chk_d.sclk_prev = sclk;
    chk_d.edges = cs_n ? 6'h00 : chk_q.edges + {5'h00, sclk & ~chk_q.sclk_prev};
  end
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      chk_q <= {6'h00, 1'b1};
    end
    else
    begin
      chk_q <= chk_d;
    end
  end
  // Frames hold one word, or the seventeen-edge realign frame
  chk_frame_edges: assert property ($rose(cs_n) |-> chk_q.edges == 6'h10 || chk_q.edges == 6'h11)
    else $error("frame edge count wrong");
  chk_sclk_idle: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("link clock not idle high");
  chk_cs_lead: assert property ($fell(cs_n) |-> sclk [*4] ##1 !sclk)
    else $error("lead time wrong");
  chk_sclk_low: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("clock low phase wrong");
  chk_sclk_high: assert property ($rose(sclk) && !cs_n |-> sclk [*4])
    else $error("clock high phase short");
  chk_gap_min: assert property ($rose(cs_n) |=> cs_n [*8])
    else $error("gap between words short");
  chk_mosi_hold: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(mosi))
    else $error("data moved while clock high");
  chk_ready_single: assert property (sample_ready_pulse |=> !sample_ready_pulse)
    else $error("ready pulse too long");
  chk_hrst_width: assert property (disable iff (reset_in) $rose(hard_rst) |-> hard_rst [*8] ##1 !hard_rst)
    else $error("hard reset width wrong");
endmodule // imsp_link_assertions
`default_nettype wire

// >>> verification/tb_imu_spi_port_data_width.sv
`timescale 1ns/10ps
`default_nettype none
module tb_imu_spi_port_data_width;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [6:0] req_addr_in = 7'h00;
  logic [7:0] req_data_in = 8'h00;
  logic recover_in = 1'b0;
  logic hard_reset_in = 1'b0;
  logic raw_valid_in = 1'b0;
  logic [2:0][15:0] raw_gyro_in = 48'h0;
  logic [2:0][19:0] raw_accel_in = 60'h0;
  logic req_ready_out, ans_valid_out, rec_busy_out, rec_ok_out, rec_fail_out;
  logic [15:0] ans_data_out;
  logic locked_a, locked_b;
  logic [15:0] v;
  int err_count = 0;
  int tests_run = 0;
  int n;
  localparam logic [15:0] RD_PROD = {1'b0, imsp_pkg::ADDR_PROD, 8'h00};
  imsp_link_if lnk ();
  imsp_link_if lnk2 ();
  // System clock
  always #20 clk_sys_in = ~clk_sys_in;
  // Host and device joined over the link
  imsp_host #(.GAP(16)) imsp_host_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .lnk(lnk.host),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .req_ready_out(req_ready_out), .ans_valid_out(ans_valid_out),
    .ans_data_out(ans_data_out), .recover_in(recover_in), .hard_reset_in(hard_reset_in),
    .rec_busy_out(rec_busy_out), .rec_ok_out(rec_ok_out), .rec_fail_out(rec_fail_out));
  imsp_device imsp_device_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .lnk(lnk.dev),
    .raw_valid_in(raw_valid_in), .raw_gyro_in(raw_gyro_in), .raw_accel_in(raw_accel_in),
    .port_locked_out(locked_a));
  // Second device driven by bench frames that break the framing
  imsp_device imsp_device_b_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .lnk(lnk2.dev),
    .raw_valid_in(1'b0), .raw_gyro_in(48'h0), .raw_accel_in(60'h0), .port_locked_out(locked_b));
  imsp_link_assertions imsp_link_assertions_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso),
    .sample_ready_pulse(lnk.sample_ready_pulse), .hard_rst(lnk.hard_rst));
  task check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  // One link word through the host request port
  task xfer(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [15:0] ans);
    int k;
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in <= a;
    req_data_in <= d;
    k = 0;
    do
    begin
      @(negedge clk_sys_in);
      k++;
    end while (req_ready_out !== 1'b1 && k < 2000);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    req_write_in <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk_sys_in);
      k++;
    end while (ans_valid_out !== 1'b1 && k < 400);
    ans = ans_data_out;
    check16("word answered", 16'h0001, {15'h0000, ans_valid_out});
  endtask
  // Register read: answer comes in the following word
  task rd(input logic [6:0] a, output logic [15:0] r);
    logic [15:0] x;
    xfer(1'b0, a, 8'h00, x);
    xfer(1'b0, imsp_pkg::ADDR_PROD, 8'h00, r);
  endtask
  task feed(input int cnt, input logic [15:0] g, input logic [19:0] ac);
    int k;
    for (k = 0; k < cnt; k++)
    begin
      @(posedge clk_sys_in);
      raw_valid_in <= 1'b1;
      raw_gyro_in[0] <= g + 16'(k);
      raw_accel_in[0] <= ac;
    end
    @(posedge clk_sys_in);
    raw_valid_in <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk_sys_in);
      k++;
    end while (lnk.sample_ready_pulse !== 1'b1 && k < 200);
    check16("sample ready", 16'h0001, {15'h0000, lnk.sample_ready_pulse});
    // Let the host see the pulse and open its new read budget
    repeat (4) @(posedge clk_sys_in);
  endtask
  // Feed one output block and check the placed gyro x words
  task block(input int cnt, input int g, input logic [15:0] base, input logic [19:0] ac);
    logic [31:0] full;
    logic [15:0] r;
    int k;
    full = 32'h0;
    for (k = 0; k < cnt; k++)
      full = full + 32'(base) + 32'(k);
    full = full << (16 - g);
    feed(cnt, base, ac);
    rd(7'h06, r);
    check16("gyro x upper", full[31:16], r);
    rd(7'h04, r);
    check16("gyro x lower", full[15:0], r);
  endtask
  // Count reads accepted before the host runs out of budget
  task count_reads(input int exp);
    int k;
    int cnt;
    logic [15:0] x;
    cnt = 0;
    do
    begin
      k = 0;
      while (req_ready_out !== 1'b1 && k < 300)
      begin
        @(negedge clk_sys_in);
        k++;
      end
      if (k < 300)
      begin
        xfer(1'b0, imsp_pkg::ADDR_PROD, 8'h00, x);
        cnt++;
      end
    end while (k < 300 && cnt < 60);
    check16("reads per interval", 16'(exp), 16'(cnt));
  endtask
  // Bench-made frame of any edge count on the second link
  task bb(input logic [15:0] w, input int cnt, output logic [15:0] r);
    int k;
    lnk2.cs_n <= 1'b0;
    #24;
    for (k = 0; k < cnt; k++)
    begin
      lnk2.sclk <= 1'b0;
      lnk2.mosi <= w[15 - (k % 16)];
      #24;
      lnk2.sclk <= 1'b1;
      #12;
      r = {r[14:0], lnk2.miso};
      #12;
    end
    lnk2.cs_n <= 1'b1;
    lnk2.mosi <= ~lnk2.mosi;
    #2000;
  endtask
  task tally_and_finish;
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #(80000 * 40);
    err_count++;
    tally_and_finish;
  end
  // Main sequence
  initial
  begin
    lnk2.sclk = 1'b1;
    lnk2.cs_n = 1'b1;
    lnk2.mosi = 1'b0;
    lnk2.hard_rst = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(imsp_pkg::ADDR_PROD, v);
    check16("product number", imsp_pkg::PROD_NUM_DEF, v);
    xfer(1'b1, imsp_pkg::ADDR_PROD, 8'h55, v);
    rd(imsp_pkg::ADDR_PROD, v);
    check16("product number kept", imsp_pkg::PROD_NUM_DEF, v);
    // Default widths, then burst of upper words
    block(1, 0, 16'h1234, 20'h12345);
    rd(7'h12, v);
    check16("accel x upper", 16'h1234, v);
    rd(7'h10, v);
    check16("accel x lower", 16'h5000, v);
    feed(1, 16'h1234, 20'h12345);
    xfer(1'b0, imsp_pkg::ADDR_BURST, 8'h00, v);
    for (n = 0; n < 6; n++)
    begin
      xfer(1'b0, imsp_pkg::ADDR_PROD, 8'h00, v);
      check16("burst word", (n % 3 == 0) ? 16'h1234 : 16'h0000, v);
    end
    // Decimation and smoothing sums
    xfer(1'b1, imsp_pkg::ADDR_DEC, 8'h07, v);
    block(8, 3, 16'h0100, 20'h00000);
    xfer(1'b1, imsp_pkg::ADDR_DEC, 8'h00, v);
    xfer(1'b1, imsp_pkg::ADDR_FILT, 8'h02, v);
    block(16, 4, 16'h0100, 20'h00000);
    xfer(1'b1, imsp_pkg::ADDR_FILT, 8'h00, v);
    // Read budget per ready interval
    feed(1, 16'h0000, 20'h00000);
    count_reads(12);
    xfer(1'b1, imsp_pkg::ADDR_DEC, 8'h02, v);
    feed(3, 16'h0000, 20'h00000);
    count_reads(36);
    feed(3, 16'h0000, 20'h00000);
    rd(imsp_pkg::ADDR_DIAG, v);
    check16("overrun flag", 16'h0000, v & 16'h0002);
    rd(imsp_pkg::ADDR_DEC, v);
    check16("decimation setting", 16'h0002, v);
    // Hard reset from the host, then the recovery loop
    @(posedge clk_sys_in);
    hard_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    hard_reset_in <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    feed(1, 16'h0000, 20'h00000);
    rd(imsp_pkg::ADDR_DEC, v);
    check16("decimation after hard reset", 16'h0000, v);
    // Hold the request until the host is idle and takes it
    @(posedge clk_sys_in);
    recover_in <= 1'b1;
    n = 0;
    while (rec_busy_out !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    check16("recovery started", 16'h0001, {15'h0000, rec_busy_out});
    @(posedge clk_sys_in);
    recover_in <= 1'b0;
    n = 0;
    while (rec_ok_out !== 1'b1 && rec_fail_out !== 1'b1 && n < 20000)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    check16("recovery result", 16'h0001, {14'h0000, rec_fail_out, rec_ok_out});
    // Excess and short frames on the second port
    bb(RD_PROD, 16, v);
    bb(RD_PROD, 16, v);
    check16("second port product", imsp_pkg::PROD_NUM_DEF, v);
    bb(RD_PROD, 20, v);
    bb(16'h0000, 17, v);
    bb(RD_PROD, 16, v);
    bb(RD_PROD, 16, v);
    check16("realigned product", imsp_pkg::PROD_NUM_DEF, v);
    bb(RD_PROD, 8, v);
    // The short frame is judged at the first edge of the next frame
    bb(RD_PROD, 16, v);
    check16("port locked", 16'h0001, {15'h0000, locked_b});
    bb(RD_PROD, 16, v);
    check16("locked answer", 16'h0000, v);
    lnk2.hard_rst <= 1'b1;
    #320;
    lnk2.hard_rst <= 1'b0;
    #400;
    check16("port unlocked", 16'h0000, {15'h0000, locked_b});
    bb(RD_PROD, 16, v);
    bb(RD_PROD, 16, v);
    check16("product after unlock", imsp_pkg::PROD_NUM_DEF, v);
    // Reads past the budget with no ready pulse set the overrun flag
    for (n = 0; n < 12; n++)
      bb(RD_PROD, 16, v);
    bb({1'b0, imsp_pkg::ADDR_DIAG, 8'h00}, 16, v);
    bb(RD_PROD, 16, v);
    check16("overrun flag set", 16'h0002, v & 16'h0002);
    check16("main port unlocked", 16'h0000, {15'h0000, locked_a});
    tally_and_finish;
  end
endmodule // tb_imu_spi_port_data_width
`default_nettype wire
